// *** shared/sld_pkg.sv ***
// package: constants and types for the serial latched output driver
package sld_pkg;
  // number of shift stages, latches and output drivers
  localparam int unsigned STAGES = 20;
  // reset value of the shift chain and output latches
  localparam logic [STAGES-1:0] CHAIN_RST = 20'h00000;
  // reset value of a settled pin level (clkLvl, datLvl, ldLvl, disLvl)
  localparam logic SYNC_RST = 1'b0;
  // synchroniser depth for pin inputs
  localparam int unsigned SYNC_DEPTH = 3;
  // output stage modes
  typedef enum logic [1:0] {
    SLD_OUT_BLANK = 2'b00,
    SLD_OUT_LIVE  = 2'b01
  } sld_mode_t;
endpackage

// *** rtl/sld_driver.sv ***
// design: 20-stage serial-in latched output driver, oversampled on ref_clk
`timescale 1ns/1ps
module sld_driver
  import sld_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              shiftClk,
  input  wire logic              serialIn,
  input  wire logic              latchLoad,
  input  wire logic              outDisable,
  output logic                   serialOut,
  output logic      [STAGES-1:0] srcOn,
  output logic      [STAGES-1:0] sinkOn
);

  // ==========================================================
  // reset release
  // ==========================================================
  logic [1:0] rstSync_r;
  logic       rstnInt;

  // async assert, clocked release through two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_r <= 2'b00;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  // release is clocked so no state flop sees reset drop close to an edge
  assign rstnInt = rstSync_r[1];

  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic [SYNC_DEPTH-1:0] clkSync;
    logic [SYNC_DEPTH-1:0] datSync;
    logic [SYNC_DEPTH-1:0] ldSync;
    logic [SYNC_DEPTH-1:0] disSync;
    logic                  clkLvl;
    logic                  datLvl;
    logic                  ldLvl;
    logic                  disLvl;
    logic [STAGES-1:0]     chain;
    logic [STAGES-1:0]     latch;
    sld_mode_t             mode;
  } sld_state_t;

  sld_state_t st_r;
  sld_state_t st_nxt;
  logic       clkRise;

  // a change counts once the second and third flops agree
  function automatic logic settle(input logic [SYNC_DEPTH-1:0] s, input logic prev);
    settle = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  // next state: sampling, shift, latch, output mode
  always_comb begin
    st_nxt = st_r;
    // every pin walks its own three flops; the first is only ever shifted on
    st_nxt.clkSync = {st_r.clkSync[1:0], shiftClk};
    st_nxt.datSync = {st_r.datSync[1:0], serialIn};
    st_nxt.ldSync  = {st_r.ldSync[1:0], latchLoad};
    st_nxt.disSync = {st_r.disSync[1:0], outDisable};
    // a level moves only once flops two and three agree, so a runt is dropped
    st_nxt.clkLvl  = settle(st_r.clkSync, st_r.clkLvl);
    st_nxt.datLvl  = settle(st_r.datSync, st_r.datLvl);
    st_nxt.ldLvl   = settle(st_r.ldSync, st_r.ldLvl);
    st_nxt.disLvl  = settle(st_r.disSync, st_r.disLvl);
    // one-cycle shift enable; the host clock never clocks a flop itself
    clkRise = st_nxt.clkLvl && !st_r.clkLvl;
    // data is taken from the settled level before the edge; host setup covers it
    if (clkRise) begin
      st_nxt.chain = {st_r.chain[STAGES-2:0], st_r.datLvl};
    end
    // transparent latch: follows the chain, including fresh shifts
    if (st_r.ldLvl) begin
      st_nxt.latch = st_nxt.chain;
    end else begin
      st_nxt.latch = st_r.latch;
    end
    // blanking follows the settled pin; latch bits are not touched here
    st_nxt.mode = st_nxt.disLvl ? SLD_OUT_BLANK : SLD_OUT_LIVE;
  end

  // single state register
  always_ff @(posedge ref_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      st_r <= '{clkSync: '0, datSync: '0, ldSync: '0, disSync: '0,
                clkLvl: SYNC_RST, datLvl: SYNC_RST, ldLvl: SYNC_RST,
                disLvl: SYNC_RST, chain: CHAIN_RST, latch: CHAIN_RST,
                mode: SLD_OUT_BLANK};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // driver stages
  // ==========================================================
  // a stage sources only when live and its latch bit is set
  // blanking masks the drivers only, so latch contents survive it
  function automatic logic driveSrc(input sld_mode_t m, input logic lat);
    // anything but live blanks, so an unknown mode fails safe
    case (m)
      SLD_OUT_LIVE: begin
        driveSrc = lat;
      end
      default: begin
        driveSrc = 1'b0;
      end
    endcase
  endfunction

  // one source and one pull-down sink per latch, one driving at a time
  // the mux stays combinational; it settles straight from registered state
  for (genvar i = 0; i < STAGES; i++) begin : g_stage
    assign srcOn[i]  = driveSrc(st_r.mode, st_r.latch[i]);
    assign sinkOn[i] = !driveSrc(st_r.mode, st_r.latch[i]);
  end

  // ==========================================================
  // serial output
  // ==========================================================
  // taken straight off the last stage for the next part in a chain
  // registered in the chain, so it cannot glitch when load or blanking move
  assign serialOut = st_r.chain[STAGES-1];

  // ==========================================================
  // assertions
  // ==========================================================
  // shift edge: the chain steps exactly once and the first stage takes the data
  a_shift_step: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    clkRise |=> st_r.chain[STAGES-1:1] == $past(st_r.chain[STAGES-2:0]))
    else $error("shift chain did not advance");
  a_shift_capture: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    clkRise |=> st_r.chain[0] == $past(st_r.datLvl))
    else $error("first stage missed serial input");
  a_chain_quiet: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    !clkRise |=> $stable(st_r.chain))
    else $error("shift chain moved without clock edge");

  // pin filters: a level holds while flops two and three disagree
  a_sync_filter: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    (st_r.clkSync[1] != st_r.clkSync[2]) |=> $stable(st_r.clkLvl))
    else $error("clock level moved on unsettled pin");
  a_data_filter: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    (st_r.datSync[1] != st_r.datSync[2]) |=> $stable(st_r.datLvl))
    else $error("data level moved on unsettled pin");
  a_load_filter: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    (st_r.ldSync[1] != st_r.ldSync[2]) |=> $stable(st_r.ldLvl))
    else $error("load level moved on unsettled pin");
  a_dis_filter: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    (st_r.disSync[1] != st_r.disSync[2]) |=> $stable(st_r.disLvl))
    else $error("disable level moved on unsettled pin");

  // serial output moves only with a shift and always carries the last stage
  a_sout_stable: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    !clkRise |=> $stable(serialOut))
    else $error("serial out changed without clock edge");
  a_sout_last: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    clkRise |=> serialOut == $past(st_r.chain[STAGES-2]))
    else $error("serial out not last stage");

  // latches: transparent while load is high, frozen while it is low
  a_latch_follow: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    st_r.ldLvl |=> st_r.latch == st_r.chain)
    else $error("latch not transparent");
  a_latch_fresh: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    (st_r.ldLvl && clkRise) |=> st_r.latch[0] == $past(st_r.datLvl))
    else $error("latch missed freshly shifted bit");
  a_latch_hold: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    !st_r.ldLvl |=> $stable(st_r.latch))
    else $error("latch changed while load low");

  // blanking masks the drivers and never touches the latches
  a_blank_keep: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    (st_r.disLvl && st_r.ldLvl) |=> st_r.latch == st_r.chain)
    else $error("blanking disturbed latches");
  a_blank_out: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    st_r.disLvl |-> (srcOn == '0) && (sinkOn == '1))
    else $error("outputs not blanked");
  a_live_out: assert property (@(posedge ref_clk) disable iff (!rstnInt)
    !st_r.disLvl |-> srcOn == st_r.latch && sinkOn == ~st_r.latch)
    else $error("outputs not from latches");

  // reset: outputs stay blanked while the internal reset is low
  a_reset_blank: assert property (@(posedge ref_clk)
    !rstnInt |-> (srcOn == '0) && (sinkOn == '1))
    else $error("outputs live during reset");

  // ==========================================================
  // coverage
  // ==========================================================
  // shift, load pulse, blanking pulse, shift while transparent, cascade rise
  c_shift: cover property (@(posedge ref_clk) disable iff (!rstnInt)
    $rose(st_r.clkLvl));
  c_load: cover property (@(posedge ref_clk) disable iff (!rstnInt)
    st_r.ldLvl ##1 !st_r.ldLvl);
  c_blank: cover property (@(posedge ref_clk) disable iff (!rstnInt)
    st_r.disLvl ##1 !st_r.disLvl);
  c_live_shift: cover property (@(posedge ref_clk) disable iff (!rstnInt)
    st_r.ldLvl && clkRise);
  c_cascade: cover property (@(posedge ref_clk) disable iff (!rstnInt)
    $rose(serialOut));

endmodule

// *** verification/sld_host_model.sv ***
// host model: drives shift clock and serial data pins
`timescale 1ns/1ps
module sld_host_model
  import sld_pkg::*;
(
  input  wire logic ref_clk,
  output logic      shiftClk,
  output logic      serialIn
);
  // =====================================================
  // pins idle: clock stands low outside transfers
  initial begin
    shiftClk = 1'b0;
    serialIn = 1'b0;
  end
  // one bit, data set up well ahead of the rising clock
  task automatic send_bit(input logic b);
    serialIn = b;
    repeat (7) @(negedge ref_clk);
    shiftClk = 1'b1;
    repeat (8) @(negedge ref_clk);
    shiftClk = 1'b0;
    repeat (7) @(negedge ref_clk);
    serialIn = ~b; // turned over for one cycle so a late sample shows up
    @(negedge ref_clk);
  endtask
  // first bit sent lands in the last stage
  task automatic send_word(input logic [STAGES-1:0] w);
    for (int i = STAGES - 1; i >= 0; i--) begin
      send_bit(w[i]);
    end
  endtask
endmodule

// *** verification/serial_latched_output_driver_bench.sv ***
// testbench: shift, latch, blanking and cascade output of the driver
`timescale 1ns/1ps
module serial_latched_output_driver_bench
  import sld_pkg::*;
;
  logic              ref_clk, rstn, shiftClk, serialIn, latchLoad, outDisable, serialOut;
  logic [STAGES-1:0] srcOn, sinkOn;
  int                nErrors, checkCount, cycles;
  localparam logic [STAGES-1:0] W1 = 20'hA5C3E;
  localparam logic [STAGES-1:0] W2 = 20'h5A3C1;
  // =====================================================
  sld_driver dut_u (.ref_clk(ref_clk), .rstn(rstn), .shiftClk(shiftClk),
    .serialIn(serialIn), .latchLoad(latchLoad), .outDisable(outDisable),
    .serialOut(serialOut), .srcOn(srcOn), .sinkOn(sinkOn));
  sld_host_model host_u (.ref_clk(ref_clk), .shiftClk(shiftClk), .serialIn(serialIn));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [STAGES-1:0] seen, input logic [STAGES-1:0] exp,
                       input string what);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic printVerdict();
    $display("errors %0d checks %0d", nErrors, checkCount);
    if (nErrors == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // pin levels need several cycles of sampling to land
  task automatic settle();
    repeat (10) @(negedge ref_clk);
  endtask
  // =====================================================
  task automatic test_shift_hold();
    host_u.send_word(W1);
    settle();
    check(srcOn, '0, "latch held");
    check(serialOut, W1[19], "cascade");
  endtask
  task automatic test_load();
    latchLoad = 1'b1;
    settle();
    check(srcOn, W1, "load src");
    check(sinkOn, ~W1, "load sink");
    check(serialOut, W1[19], "sout");
    latchLoad = 1'b0;
    settle();
  endtask
  task automatic test_blank();
    outDisable = 1'b1;
    settle();
    check(srcOn, '0, "blank src");
    check(sinkOn, '1, "blank sink");
    outDisable = 1'b0;
    settle();
    check(srcOn, W1, "after blank");
  endtask
  task automatic test_transparent();
    outDisable = 1'b1;
    latchLoad = 1'b1;
    host_u.send_word(W2);
    check(srcOn, '0, "blank in entry");
    outDisable = 1'b0;
    settle();
    check(srcOn, W2, "transparent");
    latchLoad = 1'b0;
    settle();
    host_u.send_bit(1'b1);
    settle();
    check(srcOn, W2, "hold on shift");
    check(serialOut, W2[18], "one step");
  endtask
  // =====================================================
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles >= 3000) begin
      nErrors++;
      printVerdict();
    end
  end
  initial begin
    nErrors = 0;
    checkCount = 0;
    cycles = 0;
    rstn = 1'b0;
    latchLoad = 1'b0;
    outDisable = 1'b0;
    repeat (16) @(negedge ref_clk);
    check(sinkOn, '1, "reset sink");
    rstn = 1'b1;
    settle();
    test_shift_hold();
    test_load();
    test_blank();
    test_transparent();
    printVerdict();
  end
endmodule
